// ==== rtl/analog_switch_pulldown_ctrl.sv ====
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - twelve switch channels over three registers
// - low register bits drive channels one-eight
// - bit one: switch off, pull if paired
// - high register bits 0-3 drive nine-twelve
// - unused upper bits always read zero
// - pins 1-4 as i/o: low bits0-3 zero
// - pins 5-8 as i/o: high bits0-3 zero
// - pair enable bit k serves two channels
// - pull only when enabled and switch off
// - pair enables hold whatever software writes
module analog_switch_pulldown_ctrl (
    input wire logic clock,                                 // 20 mhz system clock
    input wire logic reset_n,                               // async reset, active low
    input wire logic clk_en,                                // freezes all state when low
    input wire logic [asw_pkg::ADDR_W-1:0] addr,            // register address
    input wire logic [asw_pkg::DATA_W-1:0] wr_data,         // write data
    input wire logic wr_en,                                 // one-cycle write strobe
    input wire logic rd_en,                                 // one-cycle read strobe
    output logic [asw_pkg::DATA_W-1:0] rd_data,             // read data, cycle after rd_en
    input wire logic io_opt_low,                            // pins 1-4 are plain i/o
    input wire logic io_opt_high,                           // pins 5-8 are plain i/o
    output logic [asw_pkg::NUM_CH-1:0] switch_off,          // 1 = switch open
    output logic [asw_pkg::NUM_CH-1:0] pull_low             // 1 = pull-low connected
);
    import asw_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic io_low_s;
    logic io_high_s;
    logic [LOW_CH-1:0] sw_low_q;
    logic [LOW_CH-1:0] sw_low_d;
    logic [HIGH_CH-1:0] sw_high_q;
    logic [HIGH_CH-1:0] sw_high_d;
    logic [NUM_PAIR-1:0] pair_en_q;
    logic [NUM_PAIR-1:0] pair_en_d;
    logic [LOW_CH-1:0] low_mask;
    logic [HIGH_CH-1:0] high_mask;
    logic [DATA_W-1:0] rd_data_q;
    logic [DATA_W-1:0] rd_data_d;
    logic [NUM_CH-1:0] switch_off_q;
    logic [NUM_CH-1:0] pull_low_q;
    logic hit_low;
    logic hit_high;
    logic hit_pair;

    asw_pull_if pif ();

    // ****************************************************************
    // option straps
    // ****************************************************************
    // options are pins, so they cross into the clock domain first
    asw_sync2 #(.WIDTH(2)) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in({io_opt_high, io_opt_low}),
        .sync_out({io_high_s, io_low_s})
    );

    // shared switch bits vanish while their pins serve as plain i/o
    assign low_mask = {{(LOW_CH - SHARED_W){1'b1}}, {SHARED_W{~io_low_s}}};
    assign high_mask = {SHARED_W{~io_high_s}};

    // ****************************************************************
    // address decode
    // ****************************************************************
    assign hit_low = (addr == OFF_SW_LOW);
    assign hit_high = (addr == OFF_SW_HIGH);
    assign hit_pair = (addr == OFF_PAIR_EN);

    // ****************************************************************
    // register next values
    // ****************************************************************
    // masking the stored value too clears bits when an option appears
    always_comb begin
        sw_low_d = sw_low_q;
        if (wr_en && hit_low) begin
            sw_low_d = wr_data;
        end
        sw_low_d = sw_low_d & low_mask;
    end

    // only four channels live here, upper write bits are dropped
    always_comb begin
        sw_high_d = sw_high_q;
        if (wr_en && hit_high) begin
            sw_high_d = wr_data[SW_HIGH_LSB +: HIGH_CH];
        end
        sw_high_d = sw_high_d & high_mask;
    end

    // pair enables are plain storage; clearing shared ones is up to software
    always_comb begin
        pair_en_d = pair_en_q;
        if (wr_en && hit_pair) begin
            pair_en_d = wr_data[PAIR_EN_LSB +: NUM_PAIR];
        end
    end

    // ****************************************************************
    // register storage
    // ****************************************************************
    // undocumented reset values taken as all zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sw_low_q <= RST_SW_LOW;
            sw_high_q <= RST_SW_HIGH;
            pair_en_q <= RST_PAIR_EN;
        end else if (clk_en) begin
            sw_low_q <= sw_low_d;
            sw_high_q <= sw_high_d;
            pair_en_q <= pair_en_d;
        end
    end

    // ****************************************************************
    // switch and pull-low outputs
    // ****************************************************************
    // evaluate on next values so registered outputs track the registers
    assign pif.sw_off = {sw_high_d, sw_low_d};
    assign pif.pair_en = pair_en_d;

    asw_pull_calc #(.NUM_PAIR(NUM_PAIR)) u_calc (
        .pif(pif)
    );

    // outputs flopped for clean pins; no cycle lag versus the registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            switch_off_q <= '0;
            pull_low_q <= '0;
        end else if (clk_en) begin
            switch_off_q <= pif.sw_off;
            pull_low_q <= pif.pull;
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    // unused and unimplemented bits read zero, unmapped addresses too
    always_comb begin
        rd_data_d = RD_IDLE;
        if (rd_en) begin
            if (hit_low) begin
                rd_data_d = sw_low_q & low_mask;
            end else if (hit_high) begin
                rd_data_d[SW_HIGH_LSB +: HIGH_CH] = sw_high_q & high_mask;
            end else if (hit_pair) begin
                rd_data_d[PAIR_EN_LSB +: NUM_PAIR] = pair_en_q;
            end
        end
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= RD_IDLE;
        end else if (clk_en) begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;
    assign switch_off = switch_off_q;
    assign pull_low = pull_low_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // every channel's pull-low follows its switch and its pair enable
    for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
        a_pull_follows: assert property (
            pull_low_q[i] == (switch_off_q[i] & pair_en_q[i / 2]))
            else $error("pull-low disagrees with switch and pair enable");
    end

    a_low_write: assert property (
        clk_en && wr_en && hit_low && !io_low_s
        |=> switch_off_q[LOW_CH-1:0] == $past(wr_data))
        else $error("low switch bits did not take the write");

    a_high_write: assert property (
        clk_en && wr_en && hit_high && !io_high_s
        |=> switch_off_q[NUM_CH-1:LOW_CH] == $past(wr_data[HIGH_CH-1:0]))
        else $error("high switch bits did not take the write");

    a_pair_hold: assert property (
        clk_en && wr_en && hit_pair
        |=> pair_en_q == $past(wr_data[NUM_PAIR-1:0]) ##1 (!$past(wr_en) || !$past(clk_en)
            || !$past(hit_pair)) |-> $stable(pair_en_q) || !$past(clk_en))
        else $error("pair enable not written or not held");

    a_high_unused: assert property (
        clk_en && rd_en && hit_high |=> rd_data[DATA_W-1:HIGH_CH] == 4'h0)
        else $error("unused high register bits read nonzero");

    a_pair_unused: assert property (
        clk_en && rd_en && hit_pair |=> rd_data[DATA_W-1:NUM_PAIR] == 2'h0)
        else $error("unused pair register bits read nonzero");

    a_low_io_zero: assert property (
        clk_en && io_low_s |=> switch_off_q[SHARED_W-1:0] == 4'h0)
        else $error("low shared switch bits survive i/o option");

    a_high_io_zero: assert property (
        clk_en && rd_en && hit_high && io_high_s |=> rd_data == 8'h00)
        else $error("high switch bits read nonzero under i/o option");

    a_read_once: assert property (
        clk_en && !rd_en |=> rd_data == 8'h00)
        else $error("read data present without a read strobe");

    c_pull_on: cover property (pull_low_q != '0);
    c_write_read: cover property (wr_en && hit_pair ##1 rd_en && hit_pair);
    c_io_option: cover property ($rose(io_low_s) && sw_low_q[0]);
endmodule
`default_nettype wire

// ==== inc/asw_pkg.sv ====
package asw_pkg;
    // ****************************************************************
    // bus and channel geometry
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 12;
    localparam int NUM_PAIR = 6;
    localparam int LOW_CH = 8;
    localparam int HIGH_CH = 4;
    localparam int SHARED_W = 4;  // switch bits lost when pins are plain i/o

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFF_SW_LOW = 8'h1a;
    localparam logic [ADDR_W-1:0] OFF_SW_HIGH = 8'h1b;
    localparam logic [ADDR_W-1:0] OFF_PAIR_EN = 8'h1c;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int SW_HIGH_LSB = 0;
    localparam int PAIR_EN_LSB = 0;
    localparam logic [LOW_CH-1:0] RST_SW_LOW = 8'h00;
    localparam logic [HIGH_CH-1:0] RST_SW_HIGH = 4'h0;
    localparam logic [NUM_PAIR-1:0] RST_PAIR_EN = 6'h00;
    localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;
endpackage

// ==== inc/asw_pull_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// carries switch and pair-enable state to the pull-low evaluator
interface asw_pull_if;
    logic [asw_pkg::NUM_CH-1:0] sw_off;
    logic [asw_pkg::NUM_PAIR-1:0] pair_en;
    logic [asw_pkg::NUM_CH-1:0] pull;
    modport ctrl (output sw_off, output pair_en, input pull);
    modport calc (input sw_off, input pair_en, output pull);
endinterface
`default_nettype wire

// ==== rtl/asw_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two-flop synchroniser for option straps
// ****************************************************************
module asw_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic clock,               // system clock
    input wire logic reset_n,             // async reset, active low
    input wire logic clk_en,              // freezes both stages when low
    input wire logic [WIDTH-1:0] async_in, // levels from outside the domain
    output logic [WIDTH-1:0] sync_out     // synchronised levels
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second, never any logic
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// ==== rtl/asw_pull_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// pull-low evaluation per channel
// ****************************************************************
module asw_pull_calc #(
    parameter int NUM_PAIR = 6
) (
    asw_pull_if.calc pif  // switch state in, pull-low decision out
);
    // a channel pulls low only with its switch off and its pair enabled
    for (genvar i = 0; i < 2 * NUM_PAIR; i++) begin : g_ch
        assign pif.pull[i] = pif.sw_off[i] & pif.pair_en[i / 2];
    end
endmodule
`default_nettype wire

// ==== bench/asw_sensor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// sensor pads behind the switches and pull-low resistors
// ****************************************************************
module asw_sensor_model (
    input wire logic clock,                     // system clock
    input wire logic [11:0] switch_off,         // 1 = switch open
    input wire logic [11:0] pull_low,           // 1 = resistor connected
    output logic [11:0] pad                     // level seen on each channel
);
    logic [11:0] last_q = 12'h000;
    // remember the pads so a floating one can show the inverse
    always_ff @(posedge clock) begin
        last_q <= pad;
    end
    // open and unpulled pad floats, so it must never look like a stable level
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            pad[i] = pull_low[i] ? 1'b0 : (switch_off[i] ? ~last_q[i] : 1'b1);
        end
    end
endmodule
`default_nettype wire

// ==== bench/analog_switch_pulldown_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module analog_switch_pulldown_ctrl_tb;
    import asw_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic io_opt_low = 1'b0;
    logic io_opt_high = 1'b0;
    logic [7:0] rd_data;
    logic [11:0] switch_off;
    logic [11:0] pull_low;
    logic [11:0] pad;
    logic [7:0] m_low;
    logic [3:0] m_high;
    logic [5:0] m_pair;
    logic [31:0] lfsr = 32'h075f;
    logic [7:0] regs [3] = '{OFF_SW_LOW, OFF_SW_HIGH, OFF_PAIR_EN};
    int fail_count = 0;
    int total_checks = 0;

    analog_switch_pulldown_ctrl analog_switch_pulldown_ctrl_inst (.clock(clock),
        .reset_n(reset_n), .clk_en(clk_en), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .io_opt_low(io_opt_low), .io_opt_high(io_opt_high),
        .switch_off(switch_off), .pull_low(pull_low));
    asw_sensor_model asw_sensor_model_inst (.clock(clock), .switch_off(switch_off),
        .pull_low(pull_low), .pad(pad));

    // ****************************************************************
    // clock, compare and bus tasks
    // ****************************************************************
    initial begin
        forever #25 clock = ~clock;
    end

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk12(input string name, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            OFF_SW_LOW: return m_low;
            OFF_SW_HIGH: return {4'h0, m_high};
            OFF_PAIR_EN: return {2'b00, m_pair};
            default: return 8'h00;
        endcase
    endfunction

    // next value of the stimulus shift register
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // pull-low is worked out per channel from its pair bit
    task automatic chk_out;
        logic [11:0] sw;
        logic [11:0] pl;
        logic [11:0] fl;
        sw = {m_high, m_low};
        for (int i = 0; i < 12; i++) begin
            pl[i] = sw[i] & m_pair[i/2];
        end
        fl = sw & ~pl;
        chk12("switch_off", sw, switch_off);
        chk12("pull_low", pl, pull_low);
        // floating pads carry no level, so only driven pads are compared
        chk12("pad", ~sw, pad & ~fl);
    endtask

    // a write with clk_en low is dropped, so the model keeps its value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        if (clk_en) begin
            if (a == OFF_SW_LOW) m_low = io_opt_low ? {d[7:4], 4'h0} : d;
            if (a == OFF_SW_HIGH) m_high = io_opt_high ? 4'h0 : d[3:0];
            if (a == OFF_PAIR_EN) m_pair = d[5:0];
        end
        #1;
        chk_out;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        chk8("rd_data", exp_rd(a), rd_data);
        @(posedge clock);
        #1;
        chk8("rd_idle", RD_IDLE, rd_data);
    endtask

    // options pass a two-flop synchroniser, so allow four edges
    task automatic set_opt(input logic lo, input logic hi);
        @(posedge clock);
        io_opt_low <= lo;
        io_opt_high <= hi;
        repeat (4) @(posedge clock);
        if (lo) m_low[3:0] = 4'h0;
        if (hi) m_high = 4'h0;
        #1;
        chk_out;
    endtask

    task automatic do_reset;
        reset_n <= 1'b0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        m_low = 8'h00;
        m_high = 4'h0;
        m_pair = 6'h00;
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        do_reset;
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 3; i++) rd(regs[i]);
            for (int i = 0; i < 3; i++) wr(regs[i], 8'hff);
            for (int i = 0; i < 3; i++) rd(regs[i]);
            wr(8'h1d, 8'hff);
            rd(8'h1d);
            rd(8'h19);
            for (int k = 0; k < 6; k++) wr(OFF_PAIR_EN, 8'h01 << k);
            wr(OFF_SW_LOW, 8'h55);
            wr(OFF_SW_HIGH, 8'h0a);
            wr(OFF_PAIR_EN, 8'h3f);
            set_opt(1'b1, 1'b0);
            wr(OFF_SW_LOW, 8'hff);
            rd(OFF_SW_LOW);
            set_opt(1'b1, 1'b1);
            wr(OFF_SW_HIGH, 8'h0f);
            rd(OFF_SW_HIGH);
            // shared pair enables are cleared by software, not hardware
            wr(OFF_PAIR_EN, 8'h0c);
            set_opt(1'b0, 1'b0);
            rd(OFF_SW_LOW);
            // a frozen clock enable must drop the write
            @(posedge clock);
            clk_en <= 1'b0;
            wr(OFF_SW_LOW, 8'h00);
            @(posedge clock);
            clk_en <= 1'b1;
            rd(OFF_SW_LOW);
            repeat (40) begin
                lfsr = lfsr_next(lfsr);
                wr(8'h1a + 8'(lfsr[1:0]), lfsr[15:8]);
                rd(8'h1a + 8'(lfsr[3:2]));
            end
            // second pass starts from a reset in mid-run
            do_reset;
            #1;
            chk_out;
        end
        results;
    end

    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        results;
    end
endmodule
`default_nettype wire
